/* src/ivs_pkg.sv */
package ivs_pkg;

  localparam int SP_W          = 10;
  localparam int SP_HIGH_BITS  = SP_W - 8;
  localparam int PC_W          = 12;
  localparam int NUM_SRC       = 16;
  localparam int IDX_W         = 4;

  localparam logic [5:0] IO_SP_LOW  = 6'h3d;
  localparam logic [5:0] IO_SP_HIGH = 6'h3e;
  localparam logic [5:0] IO_STATUS  = 6'h3f;

  localparam int SR_GIE = 7;
  localparam int SR_N   = 2;
  localparam int SR_Z   = 1;
  localparam int SR_C   = 0;
  localparam int SIGN_BIT = 7;

  localparam logic [SP_W-1:0] SP_RESET  = 10'h000;
  localparam logic [SP_W-1:0] SP_ONE    = 10'h001;
  localparam logic [SP_W-1:0] SP_TWO    = 10'h002;
  localparam logic [SP_W-1:0] STACK_MIN = 10'h060;
  localparam logic [7:0]      SR_RESET  = 8'h00;

  localparam logic [PC_W-1:0] VEC_RESET = 12'h000;
  localparam logic [PC_W-1:0] VEC_FIRST = 12'h001;

  typedef enum logic [2:0] {
    STK_NONE,
    STK_PUSH,
    STK_POP,
    STK_CALL,
    STK_RET,
    STK_RETURN_FROM_INTERRUPT
  } ivs_stk_op_e;

  typedef enum logic [1:0] {
    ST_BOOT,
    ST_IDLE,
    ST_ENTRY
  } ivs_state_e;

endpackage

/* src/ivs_arb_if.sv */
`timescale 1ns/10ps
interface ivs_arb_if;
  import ivs_pkg::*;
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] first;
  logic [IDX_W-1:0]   idx;
  logic               any;
  modport enc (input req, output first, output idx, output any);
  modport ctl (output req, input first, input idx, input any);
endinterface

/* src/ivs_prio_enc.sv */
`timescale 1ns/10ps
module ivs_prio_enc
  import ivs_pkg::*;
(
  ivs_arb_if.enc arb
);
  logic [NUM_SRC:0]   seen;
  logic [IDX_W-1:0]   code;

  assign seen[0] = 1'b0;

  // Lowest index is lowest vector address, so it wins
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_src
      assign seen[g+1]    = seen[g] | arb.req[g];
      assign arb.first[g] = arb.req[g] & ~seen[g];
    end
  endgenerate

  always_comb
  begin
    code = '0;
    for (int i = 0; i < NUM_SRC; i++)
      if (arb.first[i])
        code = IDX_W'(i);
  end

  assign arb.idx = code;
  assign arb.any = seen[NUM_SRC];
endmodule // ivs_prio_enc

/* src/ivs_sp_adjust.sv */
`timescale 1ns/10ps
module ivs_sp_adjust
  import ivs_pkg::*;
(
  input  wire logic [SP_W-1:0] sp,
  input  wire ivs_stk_op_e     op,
  output logic      [SP_W-1:0] next_sp,
  output logic      [SP_W-1:0] mem_addr
);
  always_comb
  begin
    next_sp  = sp;
    mem_addr = sp;
    case (op)
      STK_PUSH:
      begin
        mem_addr = sp;
        next_sp  = sp - SP_ONE;
      end
      STK_POP:
      begin
        next_sp  = sp + SP_ONE;
        mem_addr = sp + SP_ONE;
      end
      STK_CALL:
      begin
        mem_addr = sp;
        next_sp  = sp - SP_TWO;
      end
      STK_RET, STK_RETURN_FROM_INTERRUPT:
      begin
        next_sp  = sp + SP_TWO;
        mem_addr = sp + SP_ONE;
      end
      default:
      begin
        next_sp  = sp;
        mem_addr = sp;
      end
    endcase
  end
endmodule // ivs_sp_adjust

/* src/ivs_top.sv */
`timescale 1ns/10ps
module ivs_top
  import ivs_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic [5:0]         io_addr,
  input  wire logic               io_wr,
  input  wire logic               io_rd,
  input  wire logic [7:0]         io_wdata,
  output logic      [7:0]         io_rdata,
  input  wire logic               alu_update,
  input  wire logic [7:0]         alu_result,
  input  wire logic               alu_carry,
  input  wire logic               gie_set,
  input  wire logic               gie_clr,
  input  wire logic               stack_strobe,
  input  wire ivs_stk_op_e        stack_op,
  output logic      [SP_W-1:0]    stack_ptr,
  output logic      [SP_W-1:0]    stack_addr,
  output logic                    stack_we,
  output logic                    stack_re,
  output logic                    stack_word,
  output logic                    stack_low,
  input  wire logic [NUM_SRC-1:0] irq_flag,
  input  wire logic [NUM_SRC-1:0] irq_enable,
  input  wire logic               int_window,
  output logic                    vector_valid,
  output logic      [PC_W-1:0]    vector_addr,
  output logic                    vector_is_irq,
  output logic      [NUM_SRC-1:0] irq_ack,
  output logic                    int_pending,
  output logic                    global_enable,
  output logic                    flag_negative,
  output logic                    flag_zero,
  output logic                    flag_carry
);

  ivs_state_e         state;
  ivs_stk_op_e        adj_op;
  logic [SP_W-1:0]    next_sp;
  logic [SP_W-1:0]    acc_addr;
  logic [NUM_SRC-1:0] armed;
  logic               accept;
  logic               return_from_interrupt_now;
  logic               wr_sp_low;
  logic               wr_sp_high;
  logic               wr_status;
  logic [7:0]         status_view;

  ivs_arb_if arb ();

  // Peripheral flags share core_clk, so no synchroniser here
  assign armed   = irq_flag & irq_enable;
  assign arb.req = armed;

  ivs_prio_enc u_prio
  (
    .arb (arb.enc)
  );

  // Core opens int_window only at an instruction boundary
  always_comb
  begin
    accept = 1'b0;
    if (state == ST_IDLE)
    begin
      if (int_window && global_enable && arb.any)
        accept = 1'b1;
    end
  end

  // An accepted interrupt owns the pointer that cycle
  always_comb
  begin
    adj_op = STK_NONE;
    if (accept)
      adj_op = STK_CALL;
    else if (stack_strobe)
      adj_op = stack_op;
  end

  assign return_from_interrupt_now = (adj_op == STK_RETURN_FROM_INTERRUPT);

  ivs_sp_adjust u_adj
  (
    .sp       (stack_ptr),
    .op       (adj_op),
    .next_sp  (next_sp),
    .mem_addr (acc_addr)
  );

  always_comb
  begin
    wr_sp_low  = 1'b0;
    wr_sp_high = 1'b0;
    wr_status  = 1'b0;
    if (io_wr)
    begin
      case (io_addr)
        IO_SP_LOW:  wr_sp_low  = 1'b1;
        IO_SP_HIGH: wr_sp_high = 1'b1;
        IO_STATUS:  wr_status  = 1'b1;
        default:
        begin
          wr_sp_low  = 1'b0;
          wr_sp_high = 1'b0;
          wr_status  = 1'b0;
        end
      endcase
    end
  end

  // Stack pointer register pair
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stack_ptr <= SP_RESET;
    end
    else if (adj_op != STK_NONE)
    begin
      stack_ptr <= next_sp;
    end
    else if (wr_sp_low)
    begin
      stack_ptr[7:0] <= io_wdata;
    end
    else if (wr_sp_high)
    begin
      stack_ptr[SP_W-1:8] <= io_wdata[SP_HIGH_BITS-1:0];
    end
  end

  // Memory side of each stack access
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stack_addr <= SP_RESET;
      stack_we   <= 1'b0;
      stack_re   <= 1'b0;
      stack_word <= 1'b0;
    end
    else
    begin
      stack_we   <= (adj_op == STK_PUSH) || (adj_op == STK_CALL);
      stack_re   <= (adj_op == STK_POP) || (adj_op == STK_RET) || return_from_interrupt_now;
      stack_word <= (adj_op == STK_CALL) || (adj_op == STK_RET) || return_from_interrupt_now;
      if (adj_op != STK_NONE)
        stack_addr <= acc_addr;
    end
  end

  // Warns that the pointer sits in register or I/O space
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stack_low <= 1'b1;
    end
    else
    begin
      stack_low <= (stack_ptr < STACK_MIN);
    end
  end

  // Arithmetic flags; a core update beats a software write
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flag_negative <= SR_RESET[SR_N];
      flag_zero     <= SR_RESET[SR_Z];
      flag_carry    <= SR_RESET[SR_C];
    end
    else if (alu_update)
    begin
      flag_negative <= alu_result[SIGN_BIT];
      flag_zero     <= (alu_result == 8'h00);
      flag_carry    <= alu_carry;
    end
    else if (wr_status)
    begin
      flag_negative <= io_wdata[SR_N];
      flag_zero     <= io_wdata[SR_Z];
      flag_carry    <= io_wdata[SR_C];
    end
  end

  // Entry and return leave the flags alone; handlers save them

  // Global enable; any set source beats any clear source
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      global_enable <= SR_RESET[SR_GIE];
    end
    else if (return_from_interrupt_now || gie_set)
    begin
      global_enable <= 1'b1;
    end
    else if (wr_status)
    begin
      global_enable <= io_wdata[SR_GIE];
    end
    else if (accept || gie_clr)
    begin
      global_enable <= 1'b0;
    end
  end

  // Sequencer: reset vector once, then guarded interrupt entry
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_BOOT;
    end
    else
    begin
      case (state)
        ST_BOOT:
        begin
          state <= ST_IDLE;
        end
        ST_IDLE:
        begin
          if (accept)
            state <= ST_ENTRY;
        end
        ST_ENTRY:
        begin
          // Gives the peripheral a cycle to drop its flag
          state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Vector handed to the core
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      vector_valid  <= 1'b0;
      vector_addr   <= VEC_RESET;
      vector_is_irq <= 1'b0;
    end
    else if (state == ST_BOOT)
    begin
      vector_valid  <= 1'b1;
      vector_addr   <= VEC_RESET;
      vector_is_irq <= 1'b0;
    end
    else if (accept)
    begin
      vector_valid  <= 1'b1;
      vector_addr   <= VEC_FIRST + PC_W'(arb.idx);
      vector_is_irq <= 1'b1;
    end
    else
    begin
      vector_valid  <= 1'b0;
    end
  end

  // Acknowledge pulse clears the served flag in its peripheral
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_ack <= '0;
    end
    else if (accept)
    begin
      irq_ack <= arb.first;
    end
    else
    begin
      irq_ack <= '0;
    end
  end

  // Flags stay in the peripherals while disabled, so they wait
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      int_pending <= 1'b0;
    end
    else
    begin
      int_pending <= global_enable && arb.any;
    end
  end

  always_comb
  begin
    status_view         = 8'h00;
    status_view[SR_GIE] = global_enable;
    status_view[SR_N]   = flag_negative;
    status_view[SR_Z]   = flag_zero;
    status_view[SR_C]   = flag_carry;
  end

  // Read data registered; unmapped addresses answer zero
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      io_rdata <= 8'h00;
    end
    else if (io_rd)
    begin
      case (io_addr)
        IO_SP_LOW:
        begin
          io_rdata <= stack_ptr[7:0];
        end
        IO_SP_HIGH:
        begin
          io_rdata <= {6'h00, stack_ptr[SP_W-1:8]};
        end
        IO_STATUS:
        begin
          io_rdata <= status_view;
        end
        default:
        begin
          io_rdata <= 8'h00;
        end
      endcase
    end
  end

endmodule // ivs_top

/* tb/ivs_top_assertions.sv */
`timescale 1ns/10ps
module ivs_top_assertions
  import ivs_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rstn,
  input wire logic [5:0]         io_addr,
  input wire logic               io_rd,
  input wire logic               io_wr,
  input wire logic [7:0]         io_rdata,
  input wire logic               alu_update,
  input wire logic [7:0]         alu_result,
  input wire logic               alu_carry,
  input wire logic               gie_set,
  input wire logic               stack_strobe,
  input wire ivs_stk_op_e        stack_op,
  input wire logic [SP_W-1:0]    stack_ptr,
  input wire logic [SP_W-1:0]    stack_addr,
  input wire logic               stack_we,
  input wire logic               stack_re,
  input wire logic               stack_word,
  input wire logic [NUM_SRC-1:0] irq_flag,
  input wire logic [NUM_SRC-1:0] irq_enable,
  input wire logic               int_window,
  input wire logic               vector_valid,
  input wire logic [PC_W-1:0]    vector_addr,
  input wire logic               vector_is_irq,
  input wire logic [NUM_SRC-1:0] irq_ack,
  input wire logic               global_enable,
  input wire logic               flag_negative,
  input wire logic               flag_zero,
  input wire logic               flag_carry
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Strobes that may lose to an accept, or that share a cycle with any I/O write, are left unjudged
  logic       busy;
  logic [3:0] vidx;
  assign busy = (int_window & global_enable & (|(irq_flag & irq_enable))) | io_wr;
  assign vidx = vector_addr[3:0] - 4'h1;

  property p_flags;
    alu_update |=> flag_negative == $past(alu_result[7]) && flag_carry == $past(alu_carry)
      && flag_zero == ($past(alu_result) == 8'h00);
  endproperty
  a_flags: assert property (p_flags) else $error("status flags wrong");
  property p_push;
    stack_strobe && stack_op == STK_PUSH && !busy |=> stack_we
      && stack_addr == $past(stack_ptr) && stack_ptr == $past(stack_ptr) - SP_ONE;
  endproperty
  a_push: assert property (p_push) else $error("push wrong");
  property p_pop;
    stack_strobe && stack_op == STK_POP && !busy |=> stack_re
      && stack_addr == $past(stack_ptr) + SP_ONE && stack_ptr == $past(stack_ptr) + SP_ONE;
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");
  property p_call;
    stack_strobe && stack_op == STK_CALL && !busy |=> stack_word
      && stack_ptr == $past(stack_ptr) - SP_TWO;
  endproperty
  a_call: assert property (p_call) else $error("call adjust wrong");
  property p_ret;
    stack_strobe && (stack_op == STK_RET || stack_op == STK_RETURN_FROM_INTERRUPT) && !busy |=> stack_re
      && stack_ptr == $past(stack_ptr) + SP_TWO;
  endproperty
  a_ret: assert property (p_ret) else $error("return adjust wrong");
  property p_accept;
    vector_valid && vector_is_irq |-> irq_ack == (16'h0001 << vidx)
      && $past(global_enable && int_window) && |($past(irq_flag & irq_enable) & irq_ack);
  endproperty
  a_accept: assert property (p_accept) else $error("bad accept");
  property p_prio;
    vector_valid && vector_is_irq |-> ($past(irq_flag & irq_enable) & (irq_ack - 16'h1)) == 0;
  endproperty
  a_prio: assert property (p_prio) else $error("lower vector skipped");
  property p_clear;
    vector_valid && vector_is_irq && !$past(gie_set) && !$past(io_wr) |-> !global_enable;
  endproperty
  a_clear: assert property (p_clear) else $error("global enable kept");
  property p_sph;
    io_rd && io_addr == IO_SP_HIGH |=> io_rdata[7:2] == 6'h00;
  endproperty
  a_sph: assert property (p_sph) else $error("pointer high bits set");
endmodule // ivs_top_assertions

bind ivs_top ivs_top_assertions chk (.*);

/* tb/ivs_core_model.sv */
`timescale 1ns/10ps
module ivs_core_model
  import ivs_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic [NUM_SRC-1:0] raise,
  input  wire logic [NUM_SRC-1:0] irq_ack,
  output logic      [NUM_SRC-1:0] irq_flag
);
  // Peripheral flags hold until served; a raise in the cycle of its own ack is lost
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      irq_flag <= '0;
    else
      irq_flag <= (irq_flag | raise) & ~irq_ack;
endmodule // ivs_core_model

/* tb/interrupt_vector_and_stack_tb_top.sv */
`timescale 1ns/10ps
module interrupt_vector_and_stack_tb_top;
  import ivs_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, io_wr = 1'b0, io_rd = 1'b0, alu_update = 1'b0;
  logic alu_carry = 1'b0, gie_set = 1'b0, gie_clr = 1'b0, stack_strobe = 1'b0;
  logic int_window = 1'b1;
  logic [5:0] io_addr = 6'h00;
  logic [7:0] io_wdata = 8'h00, alu_result = 8'h00, io_rdata;
  ivs_stk_op_e stack_op = STK_NONE;
  logic [NUM_SRC-1:0] irq_enable = 16'hffff, raise = 16'h0000, irq_flag, irq_ack, seen_ack;
  logic [SP_W-1:0] stack_ptr, stack_addr, sp;
  logic [PC_W-1:0] vector_addr, seen_vec;
  logic stack_we, stack_re, stack_word, stack_low, vector_valid, vector_is_irq, int_pending;
  logic global_enable, flag_negative, flag_zero, flag_carry;
  int miscompares = 0, tests_run = 0, nvec = 0;

  ivs_top dut (.*);
  ivs_core_model partner (.*);

  initial forever #5 core_clk = ~core_clk;

  // Vector pulses last one cycle, so latch them for the scenarios
  always @(posedge core_clk)
    if (vector_valid)
    begin
      seen_vec <= vector_addr;
      seen_ack <= irq_ack;
      nvec <= nvec + 1;
    end

  task automatic chk(logic [15:0] s, logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge core_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge core_clk);
    io_wr <= 1'b0;
  endtask

  task automatic rd(logic [5:0] a, logic [7:0] e);
    @(posedge core_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge core_clk);
    io_rd <= 1'b0;
    #1 chk(io_rdata, e);
  endtask

  task automatic stk(ivs_stk_op_e op, logic [SP_W-1:0] delta);
    @(posedge core_clk);
    stack_op <= op;
    stack_strobe <= 1'b1;
    @(posedge core_clk);
    stack_strobe <= 1'b0;
    sp = sp + delta;
    #1 chk(stack_ptr, sp);
  endtask

  task automatic alu(logic [7:0] r, logic c, logic [2:0] nzc);
    @(posedge core_clk);
    alu_result <= r;
    alu_carry <= c;
    alu_update <= 1'b1;
    @(posedge core_clk);
    alu_update <= 1'b0;
    #1 chk({flag_negative, flag_zero, flag_carry}, nzc);
  endtask

  task automatic irq(logic [15:0] b, logic [15:0] en, logic [11:0] v);
    int n0;
    @(posedge core_clk);
    n0 = nvec;
    raise <= b;
    irq_enable <= en;
    int_window <= 1'b1;
    @(posedge core_clk);
    raise <= 16'h0000;
    // A set pulse in the accept cycle would win over the hardware clear
    gie_set <= (b != 16'h0000) && !global_enable;
    @(posedge core_clk);
    gie_set <= 1'b0;
    repeat (20) if (nvec == n0) @(posedge core_clk);
    #1 chk(seen_vec, v);
    chk(seen_ack, 16'h0001 << (v - 12'h001));
    chk(global_enable, 1'b0);
    chk(flag_zero, 1'b1);
    sp = sp - 10'h002;
    chk(stack_ptr, sp);
    stk(STK_RETURN_FROM_INTERRUPT, 10'h002);
    chk(global_enable, 1'b1);
  endtask

  // Flag held while the core keeps its window shut
  task automatic hold;
    int n0;
    @(posedge core_clk);
    n0 = nvec;
    int_window <= 1'b0;
    irq_enable <= 16'h0020;
    raise <= 16'h0020;
    gie_set <= 1'b1;
    @(posedge core_clk);
    raise <= 16'h0000;
    gie_set <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk(int_pending, 1'b1);
    chk(16'(nvec - n0), 16'h0000);
    irq(16'h0000, 16'h0020, 12'h006);
  endtask

  task automatic sreg;
    wr(IO_STATUS, 8'hff);
    rd(IO_STATUS, 8'h87);
    @(posedge core_clk);
    gie_clr <= 1'b1;
    @(posedge core_clk);
    gie_clr <= 1'b0;
    #1 chk(global_enable, 1'b0);
    rd(IO_STATUS, 8'h07);
  endtask

  // Second reset in mid-run
  task automatic rerun;
    @(posedge core_clk);
    rstn <= 1'b0;
    @(posedge core_clk);
    #1 chk({stack_low, global_enable, stack_ptr}, {2'b10, SP_RESET});
    @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1 chk({vector_valid, vector_is_irq, vector_addr}, {2'b10, VEC_RESET});
    sp = SP_RESET;
  endtask

  task automatic results;
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1 chk(vector_addr, 12'h000);
    chk({vector_valid, vector_is_irq}, 2'b10);
    chk(stack_low, 1'b1);
    rd(IO_SP_HIGH, 8'h00);
    wr(IO_SP_LOW, 8'h5f);
    wr(IO_SP_HIGH, 8'hfe);
    rd(IO_SP_HIGH, 8'h02);
    rd(IO_SP_LOW, 8'h5f);
    chk(stack_low, 1'b0);
    rd(6'h10, 8'h00);
    sp = 10'h25f;
    stk(STK_PUSH, 10'h3ff);
    stk(STK_CALL, 10'h3fe);
    stk(STK_RET, 10'h002);
    stk(STK_POP, 10'h001);
    alu(8'h80, 1'b1, 3'b101);
    alu(8'h01, 1'b0, 3'b000);
    alu(8'h00, 1'b1, 3'b011);
    for (int i = 0; i < NUM_SRC; i++)
      irq(16'h0001 << i, 16'hffff, 12'(i + 1));
    irq(16'h0084, 16'hffff, 12'h003);
    irq(16'h0000, 16'hffff, 12'h008);
    irq(16'h0210, 16'hffef, 12'h00a);
    irq(16'h0000, 16'hffff, 12'h005);
    hold;
    sreg;
    rerun;
    results;
  end

  initial
  begin
    #100000;
    miscompares++;
    results;
  end
endmodule // interrupt_vector_and_stack_tb_top
